// ### logic/pam_pkg.sv
package pam_pkg;
   // ==============================================
   // Register byte offsets
   localparam logic [7:0] OFS_P3_LATCH   = 8'h00;
   localparam logic [7:0] OFS_P1_LATCH   = 8'h04;
   localparam logic [7:0] OFS_P3_DIR     = 8'h08;
   localparam logic [7:0] OFS_P1_DIR     = 8'h0C;
   localparam logic [7:0] OFS_FUNC_SEL   = 8'h10;
   localparam logic [7:0] OFS_P0_MASK    = 8'h14;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK   = 8'h1C;
   localparam logic [7:0] OFS_PIN_STATE  = 8'h20;

   // ==============================================
   // Function select fields
   localparam int SEL_SERIAL_A = 0;
   localparam int SEL_SERIAL_B = 1;
   localparam int SEL_QUAD     = 2;
   localparam int SEL_AND_OUT  = 3;
   localparam int SEL_W        = 4;

   // ==============================================
   // Interrupt status fields
   localparam int IRQ_EXT_A = 0;
   localparam int IRQ_EXT_B = 1;
   localparam int IRQ_W     = 2;

   // ==============================================
   // Pin positions
   localparam int P3_SER_A_RX = 0;
   localparam int P3_SER_A_TX = 1;
   localparam int P3_EXT_A    = 2;
   localparam int P3_EXT_B    = 3;
   localparam int P3_SPI_DI   = 4;
   localparam int P1_SER_B_TX = 1;
   localparam int P1_XTAL_OUT = 3;
   localparam int P1_XTAL_IN  = 4;
   localparam int P1_RF_IND_N = 6;
   localparam int P1_AND_OUT  = 7;

   // ==============================================
   // Reset values
   localparam logic [7:0]        LATCH_RST    = 8'hFF;
   localparam logic [7:0]        DIR_RST      = 8'h00;
   localparam logic [SEL_W-1:0]  SEL_RST      = 4'h0;
   localparam logic [7:0]        P0_MASK_RST  = 8'h00;
   localparam logic [IRQ_W-1:0]  IRQ_MASK_RST = 2'h0;

   // ==============================================
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pam_pkg

// ### logic/pam_port_mux.sv
`timescale 1ns/1ps
// What this block does
// - Unselected pins act as plain port bits
// - Port three bit three feeds irq b
// - Port three bit two feeds irq a
// - Serial a transmit drives port three bit one
// - Port three bit zero feeds serial a receive
// - Port three bits zero, one feed quad x
// - Port one bits three, four feed quad z
// - Quad y phase a pin feeds decoder
// - SPI data pin feeds SPI in all modes
// - And select outputs AND of port zero|mask on bit seven unless radio enable is set
// - Radio enable drives indicator on bit seven
// - Radio enable drives inverse on bit six
// - Crystal enable releases sleep crystal pins
// - RC clock enable drives RC clock out unless crystal enable is set
// - Serial b transmit drives port one bit one
module pam_port_mux (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [7:0]                s_axi_awaddr,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   output logic [1:0]                     s_axi_bresp,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   input  wire logic [7:0]                s_axi_araddr,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           irq,
   input  wire logic [7:0]                port_three_in,
   output logic [7:0]                     port_three_out,
   output logic [7:0]                     port_three_oe,
   input  wire logic [7:0]                port_one_in,
   output logic [7:0]                     port_one_out,
   output logic [7:0]                     port_one_oe,
   input  wire logic [7:0]                port_zero_value,
   input  wire logic                      serial_a_tx,
   input  wire logic                      serial_b_tx,
   input  wire logic                      rf_txrx_indicator,
   input  wire logic                      rf_indicator_en,
   input  wire logic                      sleep_xtal_en,
   input  wire logic                      internal_rc_osc,
   input  wire logic                      rc_clock_out_en,
   output logic                           ext_irq_a,
   output logic                           ext_irq_b,
   output logic                           serial_a_rx,
   output logic                           quad_x_phase_a,
   output logic                           quad_x_phase_b,
   output logic                           quad_y_phase_a,
   output logic                           quad_z_phase_a,
   output logic                           quad_z_phase_b,
   output logic                           serial_periph_data_in,
   output logic                           port_zero_and_out
);
   import pam_pkg::*;

   // ==============================================
   // Pin synchronisers
   logic [7:0] p3_meta_q, p3_sync_q, p3_prev_q;
   logic [7:0] p1_meta_q, p1_sync_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p3_meta_q <= LATCH_RST;
         p3_sync_q <= LATCH_RST;
         p3_prev_q <= LATCH_RST;
         p1_meta_q <= LATCH_RST;
         p1_sync_q <= LATCH_RST;
      end else begin
         p3_meta_q <= port_three_in;
         p3_sync_q <= p3_meta_q;
         p3_prev_q <= p3_sync_q;
         p1_meta_q <= port_one_in;
         p1_sync_q <= p1_meta_q;
      end
   end

   // ==============================================
   // Register state
   logic [7:0]       p3_latch_q, p3_latch_d, p1_latch_q, p1_latch_d;
   logic [7:0]       p3_dir_q, p3_dir_d, p1_dir_q, p1_dir_d;
   logic [SEL_W-1:0] sel_q, sel_d;
   logic [7:0]       mask_q, mask_d;
   logic [IRQ_W-1:0] irq_st_q, irq_st_d, irq_en_q, irq_en_d;
   logic             aw_held_q, aw_held_d, w_held_q, w_held_d;
   logic [7:0]       awaddr_q, awaddr_d, wdata_q, wdata_d;
   logic             wlane_q, wlane_d;
   logic             bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0]       bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0]      rdata_q, rdata_d;
   logic [IRQ_W-1:0] irq_event;
   logic             commit, wr_ok, rd_ok;
   logic [7:0]       rd_byte;

   // Falling edges on the interrupt pins are the events
   assign irq_event[IRQ_EXT_A] = p3_prev_q[P3_EXT_A] & ~p3_sync_q[P3_EXT_A];
   assign irq_event[IRQ_EXT_B] = p3_prev_q[P3_EXT_B] & ~p3_sync_q[P3_EXT_B];

   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready  = !w_held_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign commit        = aw_held_q && w_held_q && !bvalid_q;

   always_comb begin
      rd_ok = 1'b1;
      case (s_axi_araddr)
         OFS_P3_LATCH:   rd_byte = p3_latch_q;
         OFS_P1_LATCH:   rd_byte = p1_latch_q;
         OFS_P3_DIR:     rd_byte = p3_dir_q;
         OFS_P1_DIR:     rd_byte = p1_dir_q;
         OFS_FUNC_SEL:   rd_byte = {4'h0, sel_q};
         OFS_P0_MASK:    rd_byte = mask_q;
         OFS_IRQ_STATUS: rd_byte = {6'h00, irq_st_q};
         OFS_IRQ_MASK:   rd_byte = {6'h00, irq_en_q};
         OFS_PIN_STATE:  rd_byte = p3_sync_q;
         default: begin
            rd_byte = 8'h00;
            rd_ok   = 1'b0;
         end
      endcase
   end

   always_comb begin
      p3_latch_d = p3_latch_q;
      p1_latch_d = p1_latch_q;
      p3_dir_d   = p3_dir_q;
      p1_dir_d   = p1_dir_q;
      sel_d      = sel_q;
      mask_d     = mask_q;
      irq_en_d   = irq_en_q;
      irq_st_d   = irq_st_q;
      aw_held_d  = aw_held_q;
      w_held_d   = w_held_q;
      awaddr_d   = awaddr_q;
      wdata_d    = wdata_q;
      wlane_d    = wlane_q;
      bvalid_d   = bvalid_q;
      bresp_d    = bresp_q;
      rvalid_d   = rvalid_q;
      rresp_d    = rresp_q;
      rdata_d    = rdata_q;
      wr_ok      = 1'b1;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_d = 1'b1;
         awaddr_d  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_d = 1'b1;
         wdata_d  = s_axi_wdata[7:0];
         wlane_d  = s_axi_wstrb[0];
      end
      if (commit) begin
         aw_held_d = 1'b0;
         w_held_d  = 1'b0;
         bvalid_d  = 1'b1;
         case (awaddr_q)
            OFS_P3_LATCH:   if (wlane_q) p3_latch_d = wdata_q;
            OFS_P1_LATCH:   if (wlane_q) p1_latch_d = wdata_q;
            OFS_P3_DIR:     if (wlane_q) p3_dir_d = wdata_q;
            OFS_P1_DIR:     if (wlane_q) p1_dir_d = wdata_q;
            OFS_FUNC_SEL:   if (wlane_q) sel_d = wdata_q[SEL_W-1:0];
            OFS_P0_MASK:    if (wlane_q) mask_d = wdata_q;
            OFS_IRQ_MASK:   if (wlane_q) irq_en_d = wdata_q[IRQ_W-1:0];
            OFS_IRQ_STATUS: if (wlane_q) irq_st_d = irq_st_q & ~wdata_q[IRQ_W-1:0];
            OFS_PIN_STATE:  wr_ok = 1'b1;
            default:        wr_ok = 1'b0;
         endcase
         bresp_d = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      // Set beats a simultaneous clear
      irq_st_d = irq_st_d | irq_event;
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rdata_d  = {24'h000000, rd_byte};
         rresp_d  = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p3_latch_q <= LATCH_RST;
         p1_latch_q <= LATCH_RST;
         p3_dir_q   <= DIR_RST;
         p1_dir_q   <= DIR_RST;
         sel_q      <= SEL_RST;
         mask_q     <= P0_MASK_RST;
         irq_st_q   <= '0;
         irq_en_q   <= IRQ_MASK_RST;
         aw_held_q  <= 1'b0;
         w_held_q   <= 1'b0;
         awaddr_q   <= 8'h00;
         wdata_q    <= 8'h00;
         wlane_q    <= 1'b0;
         bvalid_q   <= 1'b0;
         bresp_q    <= RESP_OKAY;
         rvalid_q   <= 1'b0;
         rresp_q    <= RESP_OKAY;
         rdata_q    <= 32'h00000000;
      end else begin
         p3_latch_q <= p3_latch_d;
         p1_latch_q <= p1_latch_d;
         p3_dir_q   <= p3_dir_d;
         p1_dir_q   <= p1_dir_d;
         sel_q      <= sel_d;
         mask_q     <= mask_d;
         irq_st_q   <= irq_st_d;
         irq_en_q   <= irq_en_d;
         aw_held_q  <= aw_held_d;
         w_held_q   <= w_held_d;
         awaddr_q   <= awaddr_d;
         wdata_q    <= wdata_d;
         wlane_q    <= wlane_d;
         bvalid_q   <= bvalid_d;
         bresp_q    <= bresp_d;
         rvalid_q   <= rvalid_d;
         rresp_q    <= rresp_d;
         rdata_q    <= rdata_d;
      end
   end

   assign irq = |(irq_st_q & irq_en_q);

   // ==============================================
   // Pin output mux
   logic [7:0] p3_out_d, p3_oe_d, p1_out_d, p1_oe_d;
   logic [7:0] p3_out_q, p3_oe_q, p1_out_q, p1_oe_q;
   logic       and_val;

   assign and_val = &(port_zero_value | mask_q);

   always_comb begin
      p3_out_d = p3_latch_q;
      p3_oe_d  = p3_dir_q;
      p1_out_d = p1_latch_q;
      p1_oe_d  = p1_dir_q;
      if (sel_q[SEL_SERIAL_A]) begin
         p3_out_d[P3_SER_A_TX] = serial_a_tx;
         p3_oe_d[P3_SER_A_TX]  = 1'b1;
         p3_oe_d[P3_SER_A_RX]  = 1'b0;
      end
      if (sel_q[SEL_SERIAL_B]) begin
         p1_out_d[P1_SER_B_TX] = serial_b_tx;
         p1_oe_d[P1_SER_B_TX]  = 1'b1;
      end
      // Radio indicator outranks the AND output on bit seven
      if (rf_indicator_en) begin
         p1_out_d[P1_AND_OUT]  = rf_txrx_indicator;
         p1_oe_d[P1_AND_OUT]   = 1'b1;
         p1_out_d[P1_RF_IND_N] = ~rf_txrx_indicator;
         p1_oe_d[P1_RF_IND_N]  = 1'b1;
      end else if (sel_q[SEL_AND_OUT]) begin
         p1_out_d[P1_AND_OUT] = and_val;
         p1_oe_d[P1_AND_OUT]  = 1'b1;
      end
      // Crystal must see no driver at all, so it wins
      if (sleep_xtal_en) begin
         p1_oe_d[P1_XTAL_IN]  = 1'b0;
         p1_oe_d[P1_XTAL_OUT] = 1'b0;
      end else if (rc_clock_out_en) begin
         p1_out_d[P1_XTAL_OUT] = internal_rc_osc;
         p1_oe_d[P1_XTAL_OUT]  = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p3_out_q <= LATCH_RST;
         p1_out_q <= LATCH_RST;
         p3_oe_q  <= DIR_RST;
         p1_oe_q  <= DIR_RST;
      end else begin
         p3_out_q <= p3_out_d;
         p1_out_q <= p1_out_d;
         p3_oe_q  <= p3_oe_d;
         p1_oe_q  <= p1_oe_d;
      end
   end

   assign port_three_out    = p3_out_q;
   assign port_three_oe     = p3_oe_q;
   assign port_one_out      = p1_out_q;
   assign port_one_oe       = p1_oe_q;
   assign port_zero_and_out = and_val;

   // ==============================================
   // Inputs routed to peripherals
   assign ext_irq_b      = p3_sync_q[P3_EXT_B];
   assign ext_irq_a      = p3_sync_q[P3_EXT_A];
   // Idle-high receive line while the serial port is off the pins
   assign serial_a_rx    = sel_q[SEL_SERIAL_A] ? p3_sync_q[P3_SER_A_RX]
                                               : 1'b1;
   assign quad_x_phase_a = sel_q[SEL_QUAD] & p3_sync_q[P3_SER_A_RX];
   assign quad_x_phase_b = sel_q[SEL_QUAD] & p3_sync_q[P3_SER_A_TX];
   assign quad_z_phase_a = sel_q[SEL_QUAD] & p1_sync_q[P1_XTAL_OUT];
   assign quad_z_phase_b = sel_q[SEL_QUAD] & p1_sync_q[P1_XTAL_IN];
   assign quad_y_phase_a = sel_q[SEL_QUAD] & p3_sync_q[P3_SPI_DI];
   assign serial_periph_data_in = p3_sync_q[P3_SPI_DI];

   // ==============================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_gpio_drive: assert property (
      (sel_q == SEL_RST && !rf_indicator_en && !sleep_xtal_en
       && !rc_clock_out_en) |=> port_one_out == $past(p1_latch_q))
      else $error("port one pin out differs from latch");
   chk_irq_b_route: assert property (
      $past(port_three_in[P3_EXT_B], 2) == ext_irq_b)
      else $error("irq b not two cycles behind pin");
   chk_irq_a_route: assert property (
      $past(port_three_in[P3_EXT_A], 2) == ext_irq_a)
      else $error("irq a not two cycles behind pin");
   chk_txa_drive: assert property (
      sel_q[SEL_SERIAL_A] |=>
         port_three_oe[P3_SER_A_TX] && port_three_out[P3_SER_A_TX]
            == $past(serial_a_tx))
      else $error("serial a transmit not on pin");
   chk_rxa_route: assert property (
      sel_q[SEL_SERIAL_A] |-> serial_a_rx == p3_sync_q[P3_SER_A_RX])
      else $error("serial a receive not from pin");
   chk_quad_z: assert property (
      (sel_q[SEL_QUAD] && $stable(sel_q)) |->
         quad_z_phase_b == $past(p1_meta_q[P1_XTAL_IN]))
      else $error("quad z b not from pin");
   chk_and_out: assert property (
      (sel_q[SEL_AND_OUT] && !rf_indicator_en) |=>
         port_one_out[P1_AND_OUT] == $past(and_val))
      else $error("and output wrong");
   chk_rf_pair: assert property (
      $past(rf_indicator_en) |->
         port_one_out[P1_RF_IND_N] != port_one_out[P1_AND_OUT])
      else $error("indicator pair not inverse");
   chk_xtal_free: assert property (
      sleep_xtal_en |=> !port_one_oe[P1_XTAL_IN] && !port_one_oe[P1_XTAL_OUT])
      else $error("crystal pins driven");
   chk_txb_drive: assert property (
      sel_q[SEL_SERIAL_B] |=>
         port_one_out[P1_SER_B_TX] == $past(serial_b_tx))
      else $error("serial b transmit not on pin");
   chk_irq_sticky: assert property (
      irq_event[IRQ_EXT_A] |=> irq_st_q[IRQ_EXT_A])
      else $error("interrupt event lost");

   cov_write: cover property (commit && bresp_d == RESP_OKAY);
   cov_read_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
   cov_irq: cover property (irq);
   cov_and_out: cover property (sel_q[SEL_AND_OUT] && and_val);
endmodule : pam_port_mux

// ### sim/pam_pin_model.sv
`timescale 1ns/1ps
// ====================================
// Pins of one port as the board sees them
module pam_pin_model (
   input  wire logic [7:0] drv_out,
   input  wire logic [7:0] drv_oe,
   input  wire logic [7:0] ext_val,
   input  wire logic [7:0] ext_oe,
   output logic      [7:0] pin
);
   // Board pull-ups: a pin nobody drives reads one
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin[i] = drv_oe[i] ? drv_out[i] : (ext_oe[i] ? ext_val[i] : 1'b1);
      end
   end
endmodule : pam_pin_model

// ### sim/pam_port_mux_tb.sv
`timescale 1ns/1ps
module pam_port_mux_tb;
   import pam_pkg::*;
   // ====================================
   // Signals
   logic        aclk, aresetn, irq, s_axi_awvalid, s_axi_awready;
   logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, port_zero_value;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
   logic [3:0]  s_axi_wstrb, strb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [7:0]  port_three_in, port_three_out, port_three_oe, ext3, oe3x;
   logic [7:0]  port_one_in, port_one_out, port_one_oe, ext1, oe1x;
   logic        serial_a_tx, serial_b_tx, rf_txrx_indicator, rf_indicator_en;
   logic        sleep_xtal_en, internal_rc_osc, rc_clock_out_en, b;
   logic        ext_irq_a, ext_irq_b, serial_a_rx, quad_x_phase_a;
   logic        quad_x_phase_b, quad_y_phase_a, quad_z_phase_a;
   logic        quad_z_phase_b, serial_periph_data_in, port_zero_and_out;
   int          errors, n_checks, cyc;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] d;
      logic [1:0]  rs;
   } pam_row_s;
   // Address, value written and read back, response
   localparam pam_row_s ROWS [9] = '{
      '{OFS_P3_LATCH, 32'h5A, RESP_OKAY}, '{OFS_P1_LATCH, 32'hC3, RESP_OKAY},
      '{OFS_P3_DIR, 32'h20, RESP_OKAY}, '{OFS_P1_DIR, 32'hE0, RESP_OKAY},
      '{OFS_FUNC_SEL, 32'hF, RESP_OKAY}, '{OFS_P0_MASK, 32'h81, RESP_OKAY},
      '{OFS_IRQ_MASK, 32'h3, RESP_OKAY}, '{8'h24, 32'h77, RESP_SLVERR},
      '{OFS_FUNC_SEL, 32'h0, RESP_OKAY}};

   pam_port_mux u_dut (
      .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp, .irq, .port_three_in, .port_three_out,
      .port_three_oe, .port_one_in, .port_one_out, .port_one_oe,
      .port_zero_value, .serial_a_tx, .serial_b_tx, .rf_txrx_indicator,
      .rf_indicator_en, .sleep_xtal_en, .internal_rc_osc, .rc_clock_out_en,
      .ext_irq_a, .ext_irq_b, .serial_a_rx, .quad_x_phase_a, .quad_x_phase_b,
      .quad_y_phase_a, .quad_z_phase_a, .quad_z_phase_b,
      .serial_periph_data_in, .port_zero_and_out);
   pam_pin_model u_pin3 (.drv_out(port_three_out), .drv_oe(port_three_oe),
      .ext_val(ext3), .ext_oe(oe3x), .pin(port_three_in));
   pam_pin_model u_pin1 (.drv_out(port_one_out), .drv_oe(port_one_oe),
      .ext_val(ext1), .ext_oe(oe1x), .pin(port_one_in));

   // ====================================
   // Clock and hang guard
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errors++;
         conclude();
      end
   end

   // ====================================
   // Tasks
   task automatic conclude;
      if (errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Two sync stages plus the output register, with margin
   task automatic settle;
      repeat (4) @(posedge aclk);
   endtask : settle
   // Handshakes judged mid-cycle, where ready and valid are settled
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      logic aw_go, w_go, b_go;
      @(posedge aclk);
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr  <= a;
      s_axi_wvalid  <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= strb;
      s_axi_bready  <= 1'b1;
      do begin
         @(negedge aclk);
         aw_go = s_axi_awvalid && s_axi_awready;
         w_go  = s_axi_wvalid && s_axi_wready;
         b_go  = (s_axi_bvalid === 1'b1);
         r     = s_axi_bresp;
         @(posedge aclk);
         if (aw_go)
            s_axi_awvalid <= 1'b0;
         if (w_go)
            s_axi_wvalid <= 1'b0;
      end while (!b_go);
      s_axi_bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      logic ar_go, r_go;
      @(posedge aclk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr  <= a;
      s_axi_rready  <= 1'b1;
      do begin
         @(negedge aclk);
         ar_go = s_axi_arvalid && s_axi_arready;
         r_go  = (s_axi_rvalid === 1'b1);
         d     = s_axi_rdata;
         r     = s_axi_rresp;
         @(posedge aclk);
         if (ar_go)
            s_axi_arvalid <= 1'b0;
      end while (!r_go);
      s_axi_rready <= 1'b0;
   endtask : axi_rd
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      axi_rd(a, rd_q, rs);
      chk(rd_q, exp);
   endtask : rd_chk
   task automatic chk_reset;
      chk({port_three_out, port_three_oe, port_one_out, port_one_oe},
          32'hFF00FF00);
      rd_chk(OFS_FUNC_SEL, 32'h0);
      rd_chk(OFS_P3_LATCH, 32'hFF);
      rd_chk(OFS_P1_LATCH, 32'hFF);
   endtask : chk_reset

   // ====================================
   // Main sequence
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_wdata, s_axi_wstrb, port_zero_value, ext3, ext1, oe1x} = '0;
      {serial_a_tx, serial_b_tx, rf_txrx_indicator, rf_indicator_en} = '0;
      {sleep_xtal_en, internal_rc_osc, rc_clock_out_en, b} = '0;
      {errors, n_checks, cyc} = '0;
      strb = 4'hF;
      ext3 = 8'h80;
      oe3x = 8'hC0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk_reset();
      foreach (ROWS[i]) begin
         axi_wr(ROWS[i].a, ROWS[i].d, rs);
         chk(32'(rs), 32'(ROWS[i].rs));
         axi_rd(ROWS[i].a, rd_q, rs);
         chk(32'(rs), 32'(ROWS[i].rs));
         if (ROWS[i].rs === RESP_OKAY)
            chk(rd_q, ROWS[i].d);
      end
      // Write with no byte enabled must leave the latch alone
      strb = 4'h0;
      axi_wr(OFS_P3_LATCH, 32'h00, rs);
      strb = 4'hF;
      rd_chk(OFS_P3_LATCH, 32'h5A);
      axi_wr(OFS_IRQ_STATUS, 32'h3, rs);
      settle();
      chk({port_three_out, port_three_oe, port_one_out, port_one_oe},
          32'h5A20C3E0);
      rd_chk(OFS_PIN_STATE, 32'h9F);
      oe3x <= 8'hC4;
      settle();
      chk(32'({ext_irq_b, ext_irq_a, irq}), 32'h5);
      rd_chk(OFS_IRQ_STATUS, 32'h1);
      axi_wr(OFS_IRQ_MASK, 32'h2, rs);
      chk(32'(irq), 32'h0);
      axi_wr(OFS_IRQ_STATUS, 32'h1, rs);
      rd_chk(OFS_IRQ_STATUS, 32'h0);
      oe3x <= 8'hCC;
      settle();
      chk(32'({ext_irq_b, ext_irq_a, irq}), 32'h1);
      axi_wr(OFS_IRQ_STATUS, 32'h2, rs);
      chk(32'(irq), 32'h0);
      oe3x <= 8'hC1;
      axi_wr(OFS_FUNC_SEL, 32'h1, rs);
      for (int v = 0; v < 2; v++) begin
         b = v[0];
         serial_a_tx <= b;
         ext3 <= {7'h40, b};
         settle();
         chk(32'({port_three_out[1], port_three_oe[1]}), 32'({b, 1'b1}));
         chk(32'(serial_a_rx), 32'(b));
      end
      axi_wr(OFS_FUNC_SEL, 32'h2, rs);
      for (int v = 0; v < 2; v++) begin
         b = v[0];
         serial_b_tx <= b;
         settle();
         chk(32'({port_one_out[1], port_one_oe[1]}), 32'({b, 1'b1}));
      end
      axi_wr(OFS_FUNC_SEL, 32'h4, rs);
      oe3x <= 8'hD3;
      oe1x <= 8'h18;
      for (int v = 0; v < 2; v++) begin
         b = v[0];
         ext3 <= {3'b100, b, 2'b00, ~b, b};
         ext1 <= {3'b000, b, ~b, 3'b000};
         settle();
         chk(32'({quad_x_phase_a, quad_x_phase_b, quad_y_phase_a}),
             32'({b, ~b, b}));
         chk(32'({quad_z_phase_a, quad_z_phase_b}), 32'({~b, b}));
         chk(32'(serial_periph_data_in), 32'(b));
      end
      oe3x <= 8'hC0;
      oe1x <= 8'h00;
      axi_wr(OFS_FUNC_SEL, 32'h8, rs);
      for (int v = 0; v < 2; v++) begin
         b = v[0];
         port_zero_value <= b ? 8'h7C : 8'h7E;
         settle();
         chk(32'({port_one_out[7], port_zero_and_out}), 32'({~b, ~b}));
      end
      // Radio indicator must win over the AND output still selected
      rf_indicator_en <= 1'b1;
      for (int v = 0; v < 2; v++) begin
         b = v[0];
         rf_txrx_indicator <= b;
         settle();
         chk(32'({port_one_out[7:6], port_one_oe[7:6]}),
             32'({b, ~b, 2'b11}));
      end
      rf_indicator_en <= 1'b0;
      axi_wr(OFS_P1_DIR, 32'hFF, rs);
      sleep_xtal_en <= 1'b1;
      rc_clock_out_en <= 1'b1;
      settle();
      chk(32'(port_one_oe[4:3]), 32'h0);
      sleep_xtal_en <= 1'b0;
      for (int v = 0; v < 2; v++) begin
         b = v[0];
         internal_rc_osc <= b;
         settle();
         chk(32'({port_one_out[3], port_one_oe[3]}), 32'({b, 1'b1}));
      end
      rc_clock_out_en <= 1'b0;
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk_reset();
      conclude();
   end
endmodule : pam_port_mux_tb
